// ### dv/prc_dev_model.sv
// Model of the I/O devices behind the slots
`timescale 1ns/1ps
module prc_dev_model
(
  // Clock
  input wire logic sys_clk,
  // Control
  input wire logic devOn,
  // Device requests
  output logic [3:0] devBusReq,
  output logic [3:0] devIrqReq,
  output logic [3:0] devDmaReq,
  output logic [3:0] devIoPending
);
  // Devices keep requesting even in reset, as a software-set device might
  assign devBusReq = {4{devOn}};
  assign devIrqReq = {4{devOn}};
  assign devDmaReq = {4{devOn}};
  initial devIoPending = 4'h0;
  always @(posedge sys_clk) devIoPending <= #1 ~devIoPending;
endmodule

// ### dv/prc_reset_ctrl_props.sv
// Assertion checker for the platform reset controller
`timescale 1ns/1ps
module prc_reset_ctrl_props
#(
  parameter int NUM_SLOTS = 4,
  parameter int NUM_CPUS = 1,
  parameter logic [15:0] RESET_CYCLES = 16'h0004
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Requests
  input wire logic fullResetReq,
  input wire logic ioResetReq,
  input wire logic hibernateWake,
  input wire logic pmSupported,
  input wire logic pmIrqClear,
  input wire logic powerSwitch,
  // Observed outputs
  input wire logic [NUM_CPUS-1:0] cpuReset,
  input wire logic [NUM_SLOTS-1:0] ioReset,
  input wire logic memRetain,
  input wire logic cpuPowerEn,
  input wire logic ioPowerEn,
  input wire logic [NUM_SLOTS-1:0] busReqOut,
  input wire logic [NUM_SLOTS-1:0] irqOut,
  input wire logic [NUM_SLOTS-1:0] irqOutEn_n,
  input wire logic [NUM_SLOTS-1:0] dmaOut,
  input wire logic [NUM_SLOTS-1:0] dmaOutEn_n,
  input wire logic pmIrq,
  input wire logic [4:0] seqState
);
  localparam logic [4:0] RUN = 5'h08;
  logic [15:0] holdCnt_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Counts cycles spent in full reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || seqState != 5'h02)
      holdCnt_q <= 16'h0000;
    else
      holdCnt_q <= holdCnt_q + 16'h0001;
  end
  sequence s_fullReq;
    seqState == RUN && (fullResetReq || hibernateWake);
  endsequence
  sequence s_fullLeft;
    seqState == RUN && $past(seqState) == 5'h02;
  endsequence
  property p_quiet;
    &ioReset && $past(&ioReset) |-> busReqOut == '0 && irqOut == '0 && dmaOut == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request leaked in reset");
  property p_tri;
    &ioReset && $past(&ioReset) |-> &irqOutEn_n && &dmaOutEn_n;
  endproperty
  a_tri: assert property (p_tri) else $error("request line driven in reset");
  property p_full;
    s_fullReq |=> seqState == 5'h02 && &cpuReset && &ioReset;
  endproperty
  a_full: assert property (p_full) else $error("full reset not taken");
  property p_prio;
    seqState == RUN && fullResetReq && ioResetReq |=> seqState == 5'h02;
  endproperty
  a_prio: assert property (p_prio) else $error("full reset lost priority");
  property p_io;
    seqState == RUN && ioResetReq && pmSupported && !fullResetReq && !hibernateWake
      |=> seqState == 5'h04 && cpuReset == '0 && memRetain && &ioReset;
  endproperty
  a_io: assert property (p_io) else $error("io reset wrong");
  property p_hold;
    s_fullLeft |-> holdCnt_q == RESET_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("reset length wrong");
  property p_por;
    $fell(sys_rst) |-> seqState == 5'h01 && &cpuReset && &ioReset;
  endproperty
  a_por: assert property (p_por) else $error("power-on state wrong");
  property p_sw;
    $rose(powerSwitch) && pmSupported && !pmIrqClear |-> ##[1:4] pmIrq;
  endproperty
  a_sw: assert property (p_sw) else $error("switch irq missing");
  property p_susp;
    seqState == 5'h10 |-> memRetain && !cpuPowerEn && !ioPowerEn;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend power wrong");
endmodule
bind prc_reset_ctrl prc_reset_ctrl_props #(.NUM_SLOTS(NUM_SLOTS), .NUM_CPUS(NUM_CPUS),
  .RESET_CYCLES(RESET_CYCLES)) prc_reset_ctrl_props_inst (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .fullResetReq(fullResetReq), .ioResetReq(ioResetReq),
  .hibernateWake(hibernateWake), .pmSupported(pmSupported), .pmIrqClear(pmIrqClear),
  .powerSwitch(powerSwitch), .cpuReset(cpuReset), .ioReset(ioReset),
  .memRetain(memRetain), .cpuPowerEn(cpuPowerEn), .ioPowerEn(ioPowerEn),
  .busReqOut(busReqOut), .irqOut(irqOut), .irqOutEn_n(irqOutEn_n), .dmaOut(dmaOut),
  .dmaOutEn_n(dmaOutEn_n), .pmIrq(pmIrq), .seqState(seqState));

// ### dv/prc_reset_ctrl_tb_top.sv
// Self-checking testbench for the platform reset controller
`timescale 1ns/1ps
module prc_reset_ctrl_tb_top;
  localparam logic [15:0] RC = 16'h0004;
  logic sys_clk, sys_rst, pmSupported, pmIrqClear, powerSwitch, devOn, memRetain;
  logic cpuPowerEn, ioPowerEn, pmIrq, resetBusy, hiddenInit, handoverReady;
  logic [3:0] ioSpaceEn, slotPower, slotConfigured, slotIrqToCtrl;
  logic [5:0] req;
  logic [3:0] devBusReq, devIrqReq, devDmaReq, devIoPending, ioReset;
  logic [3:0] busReqOut, irqOut, dmaOut, irqOutEn_n, dmaOutEn_n;
  logic [0:0] cpuReset;
  logic [4:0] seqState;
  int n_mismatch, total_checks, n;
  prc_dev_model prc_dev_model_inst (.sys_clk(sys_clk), .devOn(devOn), .devBusReq(devBusReq),
    .devIrqReq(devIrqReq), .devDmaReq(devDmaReq), .devIoPending(devIoPending));
  prc_reset_ctrl #(.RESET_CYCLES(RC)) prc_reset_ctrl_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .fullResetReq(req[0]), .ioResetReq(req[1]), .handoverReq(req[3]),
    .suspendReq(req[2]), .resumeReq(req[4]), .hibernateWake(req[5]),
    .pmSupported(pmSupported), .pmIrqClear(pmIrqClear), .powerSwitch(powerSwitch),
    .slotBusType(8'h24), .slotLeftOpen(4'h5), .slotShared(4'h3), .slotSysMask(4'hC),
    .devBusReq(devBusReq), .devIrqReq(devIrqReq), .devDmaReq(devDmaReq),
    .devIoPending(devIoPending), .cpuReset(cpuReset), .ioReset(ioReset),
    .memRetain(memRetain), .cpuPowerEn(cpuPowerEn), .ioPowerEn(ioPowerEn),
    .hiddenInit(hiddenInit), .busReqOut(busReqOut), .irqOut(irqOut), .irqOutEn_n(irqOutEn_n),
    .dmaOut(dmaOut), .dmaOutEn_n(dmaOutEn_n), .ioSpaceEn(ioSpaceEn), .memSpaceEn(),
    .masterEn(), .slotPower(slotPower), .slotConfigured(slotConfigured),
    .slotIrqToCtrl(slotIrqToCtrl), .handoverReady(handoverReady),
    .pmIrq(pmIrq), .resetBusy(resetBusy), .seqState(seqState));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  task pulse(logic [5:0] v);
    req = v;
    step();
    req = 6'h00;
  endtask
  // Bounded wait until the sequencer is back in run
  task wait_run;
    n = 0;
    while (resetBusy !== 1'b0 && n < 300)
    begin
      step();
      n++;
    end
  endtask
  task t_power_on;
    chk(seqState, 5'h01);
    chk(ioReset, 4'hF);
    wait_run();
    chk(seqState, 5'h08);
    chk(cpuReset, 1'b0);
  endtask
  task t_reset(logic [5:0] v, logic [4:0] st, logic cpu, logic mem);
    pulse(v);
    chk(seqState, st);
    chk(cpuReset, cpu);
    chk(ioReset, 4'hF);
    chk(memRetain, mem);
    step();
    chk({busReqOut, irqOut, dmaOut}, 12'h000);
    chk({irqOutEn_n, dmaOutEn_n}, 8'hFF);
    wait_run();
    chk(n + 1, RC);
    chk({cpuReset, ioReset}, 5'h00);
  endtask
  task t_refused;
    pmSupported = 1'b0;
    pulse(6'h02);
    chk(seqState, 5'h08);
    step();
    pulse(6'h04);
    chk(seqState, 5'h08);
    pmSupported = 1'b1;
    step();
  endtask
  task t_suspend;
    pulse(6'h04);
    chk(seqState, 5'h10);
    chk({memRetain, cpuPowerEn, ioPowerEn}, 3'h4);
    step();
    pulse(6'h10);
    chk(seqState, 5'h02);
    wait_run();
  endtask
  task t_switch;
    powerSwitch = 1'b1;
    repeat (4) step();
    chk(pmIrq, 1'b1);
    pmIrqClear = 1'b1;
    step();
    pmIrqClear = 1'b0;
    step();
    chk(pmIrq, 1'b0);
    powerSwitch = 1'b0;
  endtask
  // Slots: 0 PCI open, 1 ISA closed, 2 card open, 3 PCI closed
  task t_handover;
    step();
    chk(slotIrqToCtrl, 4'h3);
    chk(hiddenInit, 1'b1);
    devOn = 1'b0;
    pulse(6'h08);
    step();
    chk(ioSpaceEn, 4'h1);
    chk(slotConfigured, 4'h5);
    chk(slotPower, 4'hF);
    n = 0;
    while (handoverReady !== 1'b1 && n < 4)
    begin
      step();
      n++;
    end
    chk(handoverReady, 1'b1);
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  initial
  begin
    {sys_rst, pmIrqClear, powerSwitch, devOn, pmSupported, req} = 11'h4C0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (2) step();
    sys_rst = 1'b0;
    t_power_on();
    t_reset(6'h01, 5'h02, 1'b1, 1'b0);
    t_reset(6'h20, 5'h02, 1'b1, 1'b0);
    t_reset(6'h03, 5'h02, 1'b1, 1'b0);
    t_reset(6'h02, 5'h04, 1'b0, 1'b1);
    t_refused();
    t_suspend();
    t_switch();
    t_handover();
    test_done();
  end
endmodule

// ### include/prc_pkg.sv
// Shared constants for the platform reset controller
package prc_pkg;
  // Reset pulse timing
  localparam int RESET_MIN_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // Bus classes of an I/O slot
  localparam logic [1:0] BUS_PCI = 2'h0;
  localparam logic [1:0] BUS_ISA = 2'h1;
  localparam logic [1:0] BUS_PCMCIA = 2'h2;
  // Reset values of device control state
  localparam logic SLOT_CFG_RESET = 1'h0;
  localparam logic SLOT_PWR_RESET = 1'h0;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_POWER_ON = 5'h01,
    ST_FULL_RST = 5'h02,
    ST_IO_RST = 5'h04,
    ST_RUN = 5'h08,
    ST_SUSPEND = 5'h10
  } prc_state_type;
endpackage

// ### verilog/prc_reset_ctrl.sv
// Platform reset sequencer with per-slot I/O quiet gating
//
// Function
// - A device in reset is inactive and takes no system-level part.
// - In reset, no bus transaction, interrupt or DMA request leaves a device; here from the second reset cycle on, as the gate outputs are registered.
// - Suppression happens inside each device slot, not centrally.
// - Unshared devices may also be masked at system level.
// - At handover every device sits in its bus-specific reset condition.
// - Closed PCI devices: spaces and mastering off, no interrupt, held reset.
// - Open PCI devices: configured, no interrupt, no pending I/O.
// - ISA request lines tri-stated; open ones configured from stored settings.
// - Closed card-socket devices are unpowered at handover.
// - Hidden registers are initialised consistent with the reported configuration.
// - Software can hard reset all processors and I/O together.
// - Software can reset I/O alone, leaving processors and memory intact; here only while pmSupported is set.
// - The I/O-only reset reaches devices independent of their own controls.
// - Power-on starts every device and register in hardware reset.
// - Hibernation wake looks like a normal power-on boot.
// - In suspend only memory is kept; resume goes through reboot-like reset.
// - A power switch press raises a power-management interrupt; here only while pmSupported is set.
`timescale 1ns/1ps
module prc_reset_ctrl
#(
  parameter int NUM_SLOTS = 4,
  parameter int NUM_CPUS = 1,
  parameter logic [15:0] RESET_CYCLES = 16'(prc_pkg::RESET_MIN_CYCLES)
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Software control strobes
  input wire logic fullResetReq,
  input wire logic ioResetReq,
  input wire logic handoverReq,
  input wire logic suspendReq,
  input wire logic resumeReq,
  input wire logic hibernateWake,
  input wire logic pmSupported,
  input wire logic pmIrqClear,
  // Power switch pin
  input wire logic powerSwitch,
  // Slot configuration
  input wire logic [2*NUM_SLOTS-1:0] slotBusType,
  input wire logic [NUM_SLOTS-1:0] slotLeftOpen,
  input wire logic [NUM_SLOTS-1:0] slotShared,
  input wire logic [NUM_SLOTS-1:0] slotSysMask,
  // Device requests
  input wire logic [NUM_SLOTS-1:0] devBusReq,
  input wire logic [NUM_SLOTS-1:0] devIrqReq,
  input wire logic [NUM_SLOTS-1:0] devDmaReq,
  input wire logic [NUM_SLOTS-1:0] devIoPending,
  // Reset outputs
  output logic [NUM_CPUS-1:0] cpuReset,
  output logic [NUM_SLOTS-1:0] ioReset,
  output logic memRetain,
  output logic cpuPowerEn,
  output logic ioPowerEn,
  output logic hiddenInit,
  // Gated device outputs
  output logic [NUM_SLOTS-1:0] busReqOut,
  output logic [NUM_SLOTS-1:0] irqOut,
  output logic [NUM_SLOTS-1:0] irqOutEn_n,
  output logic [NUM_SLOTS-1:0] dmaOut,
  output logic [NUM_SLOTS-1:0] dmaOutEn_n,
  output logic [NUM_SLOTS-1:0] ioSpaceEn,
  output logic [NUM_SLOTS-1:0] memSpaceEn,
  output logic [NUM_SLOTS-1:0] masterEn,
  output logic [NUM_SLOTS-1:0] slotPower,
  output logic [NUM_SLOTS-1:0] slotConfigured,
  // Status
  output logic [NUM_SLOTS-1:0] slotIrqToCtrl,
  output logic handoverReady,
  output logic pmIrq,
  output logic resetBusy,
  output logic [4:0] seqState
);
  prc_pkg::prc_state_type state_q;
  prc_pkg::prc_state_type state_d;
  logic [15:0] count_q;
  logic countDone;
  logic swSync1_q;
  logic swSync2_q;
  logic swPrev_q;
  logic handover_q;
  logic cfgLoad_q;
  logic [NUM_SLOTS-1:0] slotHoldRst;
  logic [NUM_SLOTS-1:0] slotOk;
  logic [NUM_SLOTS-1:0] slotIrqRaw;

  assign countDone = (count_q >= RESET_CYCLES - 16'h1);

  // Next state; full reset checked first so it wins a tie
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      prc_pkg::ST_POWER_ON:
      begin
        if (countDone)
          state_d = prc_pkg::ST_RUN;
      end
      prc_pkg::ST_FULL_RST:
      begin
        if (countDone)
          state_d = prc_pkg::ST_RUN;
      end
      prc_pkg::ST_IO_RST:
      begin
        if (fullResetReq)
          state_d = prc_pkg::ST_FULL_RST;
        else if (countDone)
          state_d = prc_pkg::ST_RUN;
      end
      prc_pkg::ST_RUN:
      begin
        if (fullResetReq || hibernateWake)
          state_d = prc_pkg::ST_FULL_RST;
        else if (ioResetReq && pmSupported)
          state_d = prc_pkg::ST_IO_RST;
        else if (suspendReq && pmSupported)
          state_d = prc_pkg::ST_SUSPEND;
      end
      prc_pkg::ST_SUSPEND:
      begin
        // Resume rebuilds processor and I/O state through a reset pass
        if (resumeReq || fullResetReq)
          state_d = prc_pkg::ST_FULL_RST;
      end
      default:
        state_d = prc_pkg::ST_POWER_ON;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= prc_pkg::ST_POWER_ON;
    else
      state_q <= state_d;
  end

  // Hold counter restarts on every entry into a reset state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_d != state_q)
      count_q <= 16'h0;
    else if (!countDone)
      count_q <= count_q + 16'h1;
  end

  // Reset outputs are registered so release lands on a clock edge
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cpuReset <= '1;
      ioReset <= '1;
    end
    else
    begin
      cpuReset <= {NUM_CPUS{state_d == prc_pkg::ST_POWER_ON || state_d == prc_pkg::ST_FULL_RST
        || state_d == prc_pkg::ST_SUSPEND}};
      // I/O reset only touches slots; processors keep running
      ioReset <= {NUM_SLOTS{state_d != prc_pkg::ST_RUN}};
    end
  end

  // Power rails: suspend keeps only memory alive
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cpuPowerEn <= 1'h1;
      ioPowerEn <= 1'h1;
      memRetain <= 1'h0;
    end
    else
    begin
      cpuPowerEn <= state_d != prc_pkg::ST_SUSPEND;
      ioPowerEn <= state_d != prc_pkg::ST_SUSPEND;
      memRetain <= state_d == prc_pkg::ST_SUSPEND || state_d == prc_pkg::ST_IO_RST;
    end
  end

  // Power switch sampled through two flops before edge detection
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      swSync1_q <= 1'h0;
      swSync2_q <= 1'h0;
      swPrev_q <= 1'h0;
    end
    else
    begin
      swSync1_q <= powerSwitch;
      swSync2_q <= swSync1_q;
      swPrev_q <= swSync2_q;
    end
  end

  // Sticky switch event; a new press wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pmIrq <= 1'h0;
    else if (pmSupported && swSync2_q && !swPrev_q)
      pmIrq <= 1'h1;
    else if (pmIrqClear)
      pmIrq <= 1'h0;
  end

  // Hidden register init pulses once each reset ends, before handover is possible
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cfgLoad_q <= 1'h0;
    else
      cfgLoad_q <= state_q != prc_pkg::ST_RUN && state_d == prc_pkg::ST_RUN;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_q != prc_pkg::ST_RUN)
      hiddenInit <= 1'h0;
    else if (cfgLoad_q)
      hiddenInit <= 1'h1;
  end

  // Handover window opens on request, closes on any reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_q != prc_pkg::ST_RUN)
      handover_q <= 1'h0;
    else if (handoverReq)
      handover_q <= 1'h1;
  end

  // Closed devices stay held in reset through handover, open ones run
  assign slotHoldRst = ioReset | ({NUM_SLOTS{handover_q}} & ~slotLeftOpen);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : gSlot
      prc_slot_gate uGate
      (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .slotReset(slotHoldRst[gi]),
        .busType(slotBusType[2*gi +: 2]),
        .leftOpen(slotLeftOpen[gi]),
        .handover(handover_q),
        .cfgLoad(cfgLoad_q),
        .devBusReq(devBusReq[gi]),
        .devIrqReq(devIrqReq[gi]),
        .devDmaReq(devDmaReq[gi]),
        .devIoPending(devIoPending[gi]),
        .busReqOut(busReqOut[gi]),
        .irqOut(slotIrqRaw[gi]),
        .irqOutEn_n(irqOutEn_n[gi]),
        .dmaOut(dmaOut[gi]),
        .dmaOutEn_n(dmaOutEn_n[gi]),
        .ioSpaceEn(ioSpaceEn[gi]),
        .memSpaceEn(memSpaceEn[gi]),
        .masterEn(masterEn[gi]),
        .slotPower(slotPower[gi]),
        .configured(slotConfigured[gi]),
        .handoverOk(slotOk[gi])
      );
    end
  endgenerate

  assign irqOut = slotIrqRaw;
  // System-level mask honoured only for slots sharing nothing
  assign slotIrqToCtrl = slotIrqRaw & ~(slotSysMask & ~slotShared);
  assign handoverReady = handover_q && hiddenInit && (&slotOk);
  assign resetBusy = state_q != prc_pkg::ST_RUN;
  assign seqState = state_q;
endmodule

// ### verilog/prc_slot_gate.sv
// Per-slot gate that holds one I/O device inactive while it is in reset
`timescale 1ns/1ps
module prc_slot_gate
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic slotReset,
  input wire logic [1:0] busType,
  input wire logic leftOpen,
  input wire logic handover,
  input wire logic cfgLoad,
  // Device side requests
  input wire logic devBusReq,
  input wire logic devIrqReq,
  input wire logic devDmaReq,
  input wire logic devIoPending,
  // Gated outputs
  output logic busReqOut,
  output logic irqOut,
  output logic irqOutEn_n,
  output logic dmaOut,
  output logic dmaOutEn_n,
  output logic ioSpaceEn,
  output logic memSpaceEn,
  output logic masterEn,
  output logic slotPower,
  output logic configured,
  output logic handoverOk
);
  logic cfgQ;
  logic pwrQ;
  logic quiet;

  assign quiet = slotReset;

  // Configured state restored from stored settings only for open devices
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (slotReset && !leftOpen))
      cfgQ <= prc_pkg::SLOT_CFG_RESET;
    else if (cfgLoad && leftOpen)
      cfgQ <= 1'h1;
  end

  // Socket power: closed card sockets stay unpowered
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pwrQ <= prc_pkg::SLOT_PWR_RESET;
    else if (busType == prc_pkg::BUS_PCMCIA)
      pwrQ <= leftOpen && !slotReset;
    else
      pwrQ <= 1'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busReqOut <= 1'h0;
      irqOut <= 1'h0;
      dmaOut <= 1'h0;
      irqOutEn_n <= 1'h1;
      dmaOutEn_n <= 1'h1;
      ioSpaceEn <= 1'h0;
      memSpaceEn <= 1'h0;
      masterEn <= 1'h0;
      handoverOk <= 1'h0;
    end
    else
    begin
      // Suppression sits inside the slot, not at the interrupt controller
      busReqOut <= devBusReq && !quiet;
      irqOut <= devIrqReq && !quiet;
      dmaOut <= devDmaReq && !quiet;
      // ISA request lines float whenever the slot is held quiet
      irqOutEn_n <= quiet || !(devIrqReq && busType == prc_pkg::BUS_ISA);
      dmaOutEn_n <= quiet || !(devDmaReq && busType == prc_pkg::BUS_ISA);
      ioSpaceEn <= cfgQ && !quiet && busType == prc_pkg::BUS_PCI;
      memSpaceEn <= cfgQ && !quiet && busType == prc_pkg::BUS_PCI;
      masterEn <= cfgQ && !quiet && busType == prc_pkg::BUS_PCI;
      // Handover check: open devices configured and idle, others quiet
      handoverOk <= handover && (leftOpen ? (cfgQ && !devIrqReq && !devIoPending)
        : (quiet && (busType != prc_pkg::BUS_PCMCIA || !pwrQ)));
    end
  end

  assign slotPower = pwrQ;
  assign configured = cfgQ;
endmodule
